// >>> rtl/afe_cfg_consts.svh
`ifndef AFE_CFG_CONSTS_SVH
`define AFE_CFG_CONSTS_SVH

// Register pointer offsets
`define AFE_REG_ACTIVITY 8'h01
`define AFE_REG_POLARITY 8'h02
`define AFE_REG_STANDBY 8'h1B
`define AFE_REG_MULT 8'h2B

// Standby command byte
`define AFE_STANDBY_CODE 8'h0F

// Register file size and reset values
`define AFE_REG_COUNT 64
`define AFE_REG_DEFAULT 8'h00
`define AFE_MULT_DEFAULT 8'h10

// Fixed upper six bits of the bus address
`define AFE_ADDR_UPPER 6'h26

// Deglitch length in crystal clock periods
`define AFE_FILTER_LEN 2'h3

// Bits in one byte on the serial bus
`define AFE_BYTE_BITS 4'h8

`endif

// >>> rtl/afe_cfg_pkg.sv
package afe_cfg_pkg;

  // Serial engine states
  typedef enum logic [2:0] {
    s_idle,
    s_addr,
    s_addr_ack,
    s_rx,
    s_rx_ack,
    s_tx,
    s_tx_ack
  } link_state_t;

  // Power settings handed to the system clock domain
  typedef struct packed {
    logic standby;
    logic [7:0] ref_multiplier;
  } power_cfg_t;

endpackage

// >>> rtl/line_filter.sv
`timescale 1ns/100ps
`default_nettype none
`include "afe_cfg_consts.svh"

module line_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw,
  output logic filt_q
);

  logic s1_q;
  logic s2_q;
  logic [1:0] cnt_q;

  // Two-stage synchroniser, the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // New level accepted only after it stood for the full filter length
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q <= 1'b1;
      cnt_q <= 2'h0;
    end else if (s2_q == filt_q) begin
      cnt_q <= 2'h0;
    end else if (cnt_q == `AFE_FILTER_LEN - 2'h1) begin
      filt_q <= s2_q;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  glitch_reject_a: assert property (@(posedge clk) disable iff (rst)
    $changed(filt_q) |-> (filt_q == $past(s2_q)) && ($past(s2_q) == $past(s2_q, 2)) &&
      ($past(s2_q, 2) == $past(s2_q, 3)))
    else $error("filtered line changed on a short pulse");

endmodule
`default_nettype wire

// >>> rtl/video_afe_serial_config_port.sv
// Functional notes
// - reference multiplier taken from register 0x2B
// - 0x0F written to 0x1B enters standby
// - serial port, detects, sync buffers stay alive
// - registers start at their default values
// - power-on reset restores all registers
// - low reset pin equals power-on reset
// - device only pulls data line, never clock
// - pointer advances after every data byte
// - address is 100110 plus strap bit
// - nothing happens until a start is seen
// - matching address gets acknowledge after byte
// - stop or repeated start ends transfer
// - clock line deglitched, data sampled delayed rise
// - read data changes only after delayed fall
`timescale 1ns/100ps
`default_nettype none
`include "afe_cfg_consts.svh"

module video_afe_serial_config_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic crystal_clock_input,
  input wire logic reset_n,
  input wire logic addr_strap,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] activity_status,
  input wire logic [7:0] polarity_status,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  output logic buffered_line_sync_output,
  output logic buffered_frame_sync_output,
  output var afe_cfg_pkg::power_cfg_t power_cfg,
  output logic converter_enable,
  output logic synthesizer_enable
);
  import afe_cfg_pkg::*;

  // ---------------- System clock domain: reset request ----------------
  logic pin1_q;
  logic pin2_q;
  logic rst_req_q;

  // Reset pin synchronised before it is combined with srst
  always_ff @(posedge clock) begin
    if (srst) begin
      pin1_q <= 1'b1;
      pin2_q <= 1'b1;
    end else begin
      pin1_q <= reset_n;
      pin2_q <= pin1_q;
    end
  end

  // Power-on and pin reset share one path into the crystal domain
  always_ff @(posedge clock) begin
    rst_req_q <= srst | ~pin2_q;
  end

  // Clock-side reset; the pin must clear the power settings as well
  logic sys_rst;
  assign sys_rst = srst | rst_req_q;

  // ---------------- Crystal (link) domain ----------------
  logic lr1_q;
  logic lr2_q;
  logic link_rst;

  // Reset synchroniser, the crystal runs free so reset always reaches it
  always_ff @(posedge crystal_clock_input) begin
    lr1_q <= rst_req_q;
    lr2_q <= lr1_q;
  end
  assign link_rst = lr2_q;

  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;

  // Both lines filtered alike so their relative timing survives
  line_filter u_scl_filter (
    .clk(crystal_clock_input),
    .rst(link_rst),
    .raw(scl),
    .filt_q(scl_f)
  );

  line_filter u_sda_filter (
    .clk(crystal_clock_input),
    .rst(link_rst),
    .raw(sda_in),
    .filt_q(sda_f)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge crystal_clock_input) begin
    if (link_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Bus conditions, data edges only count while clock stays high
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // Slow status inputs and sync buffers; status bytes are quasi-static
  logic [7:0] act1_q;
  logic [7:0] act2_q;
  logic [7:0] pol1_q;
  logic [7:0] pol2_q;
  logic strap1_q;
  logic strap2_q;
  logic hs1_q;
  logic hs2_q;
  logic vs1_q;
  logic vs2_q;

  always_ff @(posedge crystal_clock_input) begin
    if (link_rst) begin
      act1_q <= 8'h00;
      act2_q <= 8'h00;
      pol1_q <= 8'h00;
      pol2_q <= 8'h00;
      strap1_q <= 1'b0;
      strap2_q <= 1'b0;
    end else begin
      act1_q <= activity_status;
      act2_q <= act1_q;
      pol1_q <= polarity_status;
      pol2_q <= pol1_q;
      strap1_q <= addr_strap;
      strap2_q <= strap1_q;
    end
  end

  // Sync buffers run on the crystal so standby leaves them alive
  always_ff @(posedge crystal_clock_input) begin
    if (link_rst) begin
      hs1_q <= 1'b0;
      hs2_q <= 1'b0;
      vs1_q <= 1'b0;
      vs2_q <= 1'b0;
      buffered_line_sync_output <= 1'b0;
      buffered_frame_sync_output <= 1'b0;
    end else begin
      hs1_q <= line_sync_in;
      hs2_q <= hs1_q;
      vs1_q <= frame_sync_in;
      vs2_q <= vs1_q;
      buffered_line_sync_output <= hs2_q;
      buffered_frame_sync_output <= vs2_q;
    end
  end

  // Configuration register file
  logic [7:0] mem [0:`AFE_REG_COUNT-1];

  // Register value seen by a read at the given pointer
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    if (a == `AFE_REG_ACTIVITY) begin
      return act2_q;
    end else if (a == `AFE_REG_POLARITY) begin
      return pol2_q;
    end else if (a < 8'(`AFE_REG_COUNT)) begin
      return mem[a[5:0]];
    end else begin
      return 8'h00;
    end
  endfunction

  // Reset value of each register slot
  function automatic logic [7:0] reg_default(input logic [7:0] a);
    return (a == `AFE_REG_MULT) ? `AFE_MULT_DEFAULT : `AFE_REG_DEFAULT;
  endfunction

  link_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic first_q;
  logic host_nack_q;
  logic addr_match;
  logic wr_en;
  logic [7:0] rd_byte;

  assign addr_match = shift_q[7:1] == {`AFE_ADDR_UPPER, strap2_q};
  // Byte the next read slot sends, at the current pointer
  assign rd_byte = reg_read(ptr_q);
  // Byte after the pointer byte lands in the register file
  assign wr_en = scl_fall & ~start_det & ~stop_det & (state_q == s_rx) &
    (bit_cnt_q == `AFE_BYTE_BITS) & ~first_q;

  // Serial engine; stop and start override any byte in flight
  always_ff @(posedge crystal_clock_input) begin
    if (link_rst) begin
      state_q <= s_idle;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      host_nack_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_q <= s_idle;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state_q <= s_addr;
      bit_cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_q)
        s_addr, s_rx: begin
          shift_q <= {shift_q[6:0], sda_f};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        s_tx: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        s_tx_ack: begin
          host_nack_q <= sda_f;
        end
        s_idle, s_addr_ack, s_rx_ack: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        s_idle: begin
        end
        s_addr: begin
          if (bit_cnt_q == `AFE_BYTE_BITS) begin
            if (addr_match) begin
              state_q <= s_addr_ack;
              sda_oe <= 1'b1;
              rw_q <= shift_q[0];
              first_q <= 1'b1;
            end else begin
              state_q <= s_idle;
            end
          end
        end
        s_addr_ack: begin
          bit_cnt_q <= 4'h0;
          if (rw_q) begin
            state_q <= s_tx;
            shift_q <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end else begin
            state_q <= s_rx;
            sda_oe <= 1'b0;
          end
        end
        s_rx: begin
          if (bit_cnt_q == `AFE_BYTE_BITS) begin
            state_q <= s_rx_ack;
            sda_oe <= 1'b1;
            first_q <= 1'b0;
            if (first_q) begin
              ptr_q <= shift_q;
            end else begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        s_rx_ack: begin
          state_q <= s_rx;
          bit_cnt_q <= 4'h0;
          sda_oe <= 1'b0;
        end
        s_tx: begin
          if (bit_cnt_q == `AFE_BYTE_BITS) begin
            state_q <= s_tx_ack;
            sda_oe <= 1'b0;
            ptr_q <= ptr_q + 8'h01;
          end else begin
            shift_q <= {shift_q[6:0], 1'b0};
            sda_oe <= ~shift_q[6];
          end
        end
        s_tx_ack: begin
          bit_cnt_q <= 4'h0;
          if (host_nack_q) begin
            state_q <= s_idle;
          end else begin
            state_q <= s_tx;
            shift_q <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end
        end
      endcase
    end
  end

  // Open drain: the device only ever pulls low, never drives the clock
  always_ff @(posedge crystal_clock_input) begin
    sda_out <= 1'b0;
  end

  // Register file writes; reset reloads every default
  always_ff @(posedge crystal_clock_input) begin
    if (link_rst) begin
      for (int i = 0; i < `AFE_REG_COUNT; i++) begin
        mem[i] <= reg_default(8'(i));
      end
    end else if (wr_en && ptr_q < 8'(`AFE_REG_COUNT)) begin
      mem[ptr_q[5:0]] <= shift_q;
    end
  end

  // Crossing of the power settings: snapshot held until acknowledged
  power_cfg_t cur_cfg;
  power_cfg_t snap_q;
  logic req_q;
  logic ack1_q;
  logic ack2_q;
  logic req_m1_q;
  logic req_m2_q;
  logic req_m3_q;

  assign cur_cfg = {mem[6'(`AFE_REG_STANDBY)] == `AFE_STANDBY_CODE, mem[6'(`AFE_REG_MULT)]};

  always_ff @(posedge crystal_clock_input) begin
    if (link_rst) begin
      snap_q <= {1'b0, `AFE_MULT_DEFAULT};
      req_q <= 1'b0;
      ack1_q <= 1'b0;
      ack2_q <= 1'b0;
    end else begin
      ack1_q <= req_m3_q;
      ack2_q <= ack1_q;
      if (req_q == ack2_q && cur_cfg != snap_q) begin
        snap_q <= cur_cfg;
        req_q <= ~req_q;
      end
    end
  end

  // ---------------- System clock domain: power controls ----------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_m1_q <= 1'b0;
      req_m2_q <= 1'b0;
      req_m3_q <= 1'b0;
    end else begin
      req_m1_q <= req_q;
      req_m2_q <= req_m1_q;
      req_m3_q <= req_m2_q;
    end
  end

  // Snapshot is stable while the toggle is in flight
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      power_cfg <= {1'b0, `AFE_MULT_DEFAULT};
    end else if (req_m2_q != req_m3_q) begin
      power_cfg <= snap_q;
    end
  end

  // Converters and synthesizer follow the standby setting
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      converter_enable <= 1'b0;
      synthesizer_enable <= 1'b0;
    end else begin
      converter_enable <= ~power_cfg.standby;
      synthesizer_enable <= ~power_cfg.standby;
    end
  end

  // ---------------- Checks ----------------
  ack_on_match_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    (state_q == s_addr) && scl_fall && !stop_det && !start_det && (bit_cnt_q == 4'h8) && addr_match
    |=> sda_oe && (state_q == s_addr_ack))
    else $error("matching address not acknowledged");

  no_ack_mismatch_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    (state_q == s_addr) && scl_fall && (bit_cnt_q == 4'h8) && !addr_match
    |=> !sda_oe && (state_q == s_idle))
    else $error("foreign address acknowledged");

  ptr_rx_step_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    (state_q == s_rx) && scl_fall && (bit_cnt_q == 4'h8) && !first_q
    |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance after write");

  ptr_tx_step_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    (state_q == s_tx) && scl_fall && (bit_cnt_q == 4'h8)
    |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance after read");

  start_seen_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    start_det && !stop_det |=> (state_q == s_addr) && (bit_cnt_q == 4'h0))
    else $error("start not taken");

  idle_quiet_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    (state_q == s_idle) && !start_det |=> (state_q == s_idle) && !sda_oe)
    else $error("activity without start");

  sda_on_fall_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    $changed(sda_oe) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("data line moved outside a clock fall");

  standby_cmd_a: assert property (@(posedge crystal_clock_input) disable iff (link_rst)
    wr_en && (ptr_q == 8'h1B) |=> cur_cfg.standby == ($past(shift_q) == 8'h0F))
    else $error("standby command not decoded");

  power_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
    power_cfg.standby |=> !converter_enable && !synthesizer_enable)
    else $error("converters left on in standby");

  mult_cross_a: assert property (@(posedge clock) disable iff (sys_rst)
    req_m2_q != req_m3_q |=> power_cfg.ref_multiplier == $past(snap_q.ref_multiplier))
    else $error("multiplier not carried across");

endmodule
`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input wire logic clk,
  output logic scl,
  output logic host_oe,
  input wire logic sda
);
  // Quarter of a bit slot in system clocks, well above the deglitch latency
  localparam int Q = 8;

  // Only the host moves the clock line; data is only ever pulled low
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end

  // Lines only change at a system clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data changes mid low phase, stays put while the clock is high
  task automatic bit_slot(input logic b, output logic r);
    wait_clk(Q);
    host_oe <= ~b;
    wait_clk(Q);
    scl <= 1'b1;
    wait_clk(2 * Q);
    r = sda;
    scl <= 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    wait_clk(Q);
    host_oe <= 1'b0;
    wait_clk(Q);
    scl <= 1'b1;
    wait_clk(2 * Q);
    host_oe <= 1'b1;
    wait_clk(2 * Q);
    scl <= 1'b0;
  endtask

  // Stop: data rises while the clock is high, bus left idle
  task automatic stop();
    wait_clk(Q);
    host_oe <= 1'b1;
    wait_clk(Q);
    scl <= 1'b1;
    wait_clk(2 * Q);
    host_oe <= 1'b0;
    wait_clk(2 * Q);
  endtask

  // One-clock pulse on the low clock line, shorter than the deglitch span
  task automatic glitch();
    wait_clk(Q);
    scl <= 1'b1;
    wait_clk(1);
    scl <= 1'b0;
  endtask

  // One byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], r[i]);
    end
    bit_slot(ack_in, ack);
  endtask
endmodule

`default_nettype wire

// >>> test/video_afe_serial_config_port_test.sv
`timescale 1ns/100ps
`default_nettype none

module video_afe_serial_config_port_test;
  import afe_cfg_pkg::*;

  logic clock = 1'b0;
  logic xtal = 1'b0;
  logic srst = 1'b1;
  logic reset_n = 1'b1;
  logic addr_strap = 1'b0;
  logic [7:0] activity_status = 8'hA5;
  logic [7:0] polarity_status = 8'h3C;
  logic line_sync_in = 1'b0;
  logic frame_sync_in = 1'b0;
  logic scl, host_oe, sda_out, sda_oe, line_out, frame_out, conv_en, synth_en;
  power_cfg_t power_cfg;
  wire logic sda;
  int fails = 0;
  int checked = 0;

  // Open-drain wire with pull-up
  assign sda = ~(sda_oe | host_oe);

  // Clocks with unrelated periods
  always #10 clock = ~clock;
  always #7.5 xtal = ~xtal;

  video_afe_serial_config_port video_afe_serial_config_port_i (
    .clock(clock), .srst(srst), .crystal_clock_input(xtal), .reset_n(reset_n),
    .addr_strap(addr_strap), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .activity_status(activity_status), .polarity_status(polarity_status),
    .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
    .buffered_line_sync_output(line_out), .buffered_frame_sync_output(frame_out),
    .power_cfg(power_cfg), .converter_enable(conv_en), .synthesizer_enable(synth_en)
  );

  host_model host_model_i (.clk(clock), .scl(scl), .host_oe(host_oe), .sda(sda));

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  // Power settings and both enables, which must mirror standby
  task automatic cmp_power(input logic std, input logic [7:0] mult);
    cmp_bit(power_cfg.standby, std);
    cmp_byte(power_cfg.ref_multiplier, mult);
    cmp_bit(conv_en, ~std);
    cmp_bit(synth_en, ~std);
  endtask

  // Ack slot reads 0 when the device pulls the wire
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic a;
    host_model_i.xfer(d, 1'b1, r, a);
    cmp_bit(a, exp_ack);
  endtask

  task automatic recv(input logic [7:0] exp, input logic last);
    logic [7:0] r;
    logic a;
    host_model_i.xfer(8'hFF, last, r, a);
    cmp_byte(r, exp);
  endtask

  // Settle time covers the crossing into the system clock domain
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host_model_i.start();
    send(8'h98, 1'b0);
    send(ptr, 1'b0);
    send(d, 1'b0);
    host_model_i.stop();
    repeat (20) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    host_model_i.start();
    send(8'h98, 1'b0);
    send(ptr, 1'b0);
    host_model_i.start();
    send(8'h99, 1'b0);
    recv(exp, 1'b1);
    host_model_i.stop();
  endtask

  task automatic t_defaults();
    cmp_power(1'b0, 8'h10);
    rd(8'h00, 8'h00);
    cmp_bit(sda_out, 1'b0);
  endtask

  task automatic t_standby();
    wr(8'h1B, 8'h0F);
    cmp_power(1'b1, 8'h10);
    rd(8'h01, 8'hA5);
    rd(8'h02, 8'h3C);
    @(posedge clock);
    line_sync_in <= 1'b1;
    frame_sync_in <= 1'b1;
    repeat (6) @(posedge clock);
    cmp_bit(line_out, 1'b1);
    cmp_bit(frame_out, 1'b1);
    wr(8'h1B, 8'h0E);
    cmp_power(1'b0, 8'h10);
  endtask

  // Burst write then burst read across a repeated start
  task automatic t_burst();
    host_model_i.start();
    send(8'h98, 1'b0);
    send(8'h2A, 1'b0);
    host_model_i.glitch();
    send(8'h11, 1'b0);
    send(8'h0C, 1'b0);
    host_model_i.stop();
    repeat (20) @(posedge clock);
    cmp_power(1'b0, 8'h0C);
    host_model_i.start();
    send(8'h98, 1'b0);
    send(8'h2A, 1'b0);
    host_model_i.start();
    send(8'h99, 1'b0);
    recv(8'h11, 1'b0);
    recv(8'h0C, 1'b1);
    host_model_i.stop();
  endtask

  task automatic t_address();
    send(8'h98, 1'b1);
    host_model_i.start();
    send(8'h9A, 1'b1);
    host_model_i.stop();
    @(posedge clock);
    addr_strap <= 1'b1;
    repeat (10) @(posedge clock);
    host_model_i.start();
    send(8'h98, 1'b1);
    host_model_i.start();
    send(8'h9A, 1'b0);
    send(8'h2B, 1'b0);
    send(8'h0D, 1'b0);
    host_model_i.stop();
    repeat (20) @(posedge clock);
    cmp_power(1'b0, 8'h0D);
    addr_strap <= 1'b0;
    repeat (10) @(posedge clock);
  endtask

  task automatic t_reset_pin();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    cmp_bit(conv_en, 1'b0);
    cmp_bit(synth_en, 1'b0);
    reset_n <= 1'b1;
    repeat (20) @(posedge clock);
    cmp_power(1'b0, 8'h10);
    rd(8'h2A, 8'h00);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Whole run is a few hundred microseconds; a hang ends here
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (20) @(posedge clock);
    t_defaults();
    t_standby();
    t_burst();
    t_address();
    t_reset_pin();
    print_verdict();
  end
endmodule

`default_nettype wire
